// ### rtl/mcs_top.sv
// Design decisions made here: the register addresses and register access over APB.
`timescale 1ns/1ps
`default_nettype none
module mcs_top #(
	parameter int unsigned ADDR_W = 8
) (
	input wire logic mclk,
	input wire logic nrst,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	output logic timer_a_clock_on,
	output logic timer_f_clock_on,
	output logic adc_clock_on,
	output logic serial_if_clock_on,
	output logic lcd_clock_on,
	output logic pwm_one_clock_on,
	output logic event_counter_clock_on,
	output logic pwm_two_clock_on,
	output logic [7:0] module_clk
);

	if (ADDR_W < 4 || ADDR_W > 32) begin : g_bad_addr_w
		$error("ADDR_W must lie between 4 and 32");
	end

	mcs_pkg::mcs_state_t st_r;
	mcs_pkg::mcs_state_t st_nxt;

	logic [7:0] mod_en;
	wire logic [7:0] gate_en_q;
	wire logic [7:0] gclk_w;

	function automatic logic [1:0] reg_sel(input logic [ADDR_W-1:0] a);
		logic [1:0] s;
		s = 2'h3;
		if (a == ADDR_W'(mcs_pkg::MCS_OFS_GRP_ONE)) begin
			s = 2'h0;
		end else if (a == ADDR_W'(mcs_pkg::MCS_OFS_GRP_TWO)) begin
			s = 2'h1;
		end else if (a == ADDR_W'(mcs_pkg::MCS_OFS_HALTED)) begin
			s = 2'h2;
		end
		return s;
	endfunction

	logic access;
	logic [1:0] sel;
	assign access = psel & penable & ~st_r.pready;
	assign sel = reg_sel(paddr);

	always_comb begin
		st_nxt = st_r;
		st_nxt.pready = 1'b0;
		st_nxt.pslverr = 1'b0;
		// Answer one cycle into the access phase; pready drops right after
		if (access) begin
			st_nxt.pready = 1'b1;
			st_nxt.prdata = 32'h0000_0000;
			unique case (sel)
				2'h0: begin
					if (pwrite && pstrb[0]) begin
						st_nxt.grp_one = pwdata[7:0];
					end
					st_nxt.prdata = {24'h00_0000, st_r.grp_one};
				end
				2'h1: begin
					if (pwrite && pstrb[0]) begin
						st_nxt.grp_two = pwdata[7:0];
					end
					st_nxt.prdata = {24'h00_0000, st_r.grp_two};
				end
				2'h2: begin
					// Read-only view of clocks actually stopped at the gates
					st_nxt.prdata = {24'h00_0000, ~gate_en_q};
				end
				2'h3: begin
					st_nxt.pslverr = 1'b1;
				end
			endcase
		end
	end

	always_ff @(posedge mclk) begin
		if (!nrst) begin
			st_r <= mcs_pkg::MCS_STATE_RESET;
		end else begin
			st_r <= st_nxt;
		end
	end

	// Map register bits onto the module clock vector
	always_comb begin
		mod_en = 8'h00;
		mod_en[mcs_pkg::MCS_MOD_TIMER_A] = st_r.grp_one[mcs_pkg::MCS_BIT_TIMER_A];
		mod_en[mcs_pkg::MCS_MOD_TIMER_F] = st_r.grp_one[mcs_pkg::MCS_BIT_TIMER_F];
		mod_en[mcs_pkg::MCS_MOD_ADC] = st_r.grp_one[mcs_pkg::MCS_BIT_ADC];
		mod_en[mcs_pkg::MCS_MOD_SERIAL] = st_r.grp_one[mcs_pkg::MCS_BIT_SERIAL];
		mod_en[mcs_pkg::MCS_MOD_LCD] = st_r.grp_two[mcs_pkg::MCS_BIT_LCD];
		mod_en[mcs_pkg::MCS_MOD_PWM_ONE] = st_r.grp_two[mcs_pkg::MCS_BIT_PWM_ONE];
		mod_en[mcs_pkg::MCS_MOD_EVENT_CNT] = st_r.grp_two[mcs_pkg::MCS_BIT_EVENT_CNT];
		mod_en[mcs_pkg::MCS_MOD_PWM_TWO] = st_r.grp_two[mcs_pkg::MCS_BIT_PWM_TWO];
	end

	// One gate per module, so stopping one never touches another
	for (genvar i = 0; i < mcs_pkg::MCS_MOD_N; i++) begin : g_gate
		mcs_clock_gate u_gate (
			.mclk(mclk),
			.nrst(nrst),
			.en(mod_en[i]),
			.en_q(gate_en_q[i]),
			.gclk(gclk_w[i])
		);
	end

	assign module_clk = gclk_w;
	assign prdata = st_r.prdata;
	assign pready = st_r.pready;
	assign pslverr = st_r.pslverr;
	assign timer_a_clock_on = mod_en[mcs_pkg::MCS_MOD_TIMER_A];
	assign timer_f_clock_on = mod_en[mcs_pkg::MCS_MOD_TIMER_F];
	assign adc_clock_on = mod_en[mcs_pkg::MCS_MOD_ADC];
	assign serial_if_clock_on = mod_en[mcs_pkg::MCS_MOD_SERIAL];
	assign lcd_clock_on = mod_en[mcs_pkg::MCS_MOD_LCD];
	assign pwm_one_clock_on = mod_en[mcs_pkg::MCS_MOD_PWM_ONE];
	assign event_counter_clock_on = mod_en[mcs_pkg::MCS_MOD_EVENT_CNT];
	assign pwm_two_clock_on = mod_en[mcs_pkg::MCS_MOD_PWM_TWO];

	sequence s_wr_grp_one;
		psel && penable && !pready && pwrite && pstrb[0] && sel == 2'h0;
	endsequence

	sequence s_wr_grp_two;
		psel && penable && !pready && pwrite && pstrb[0] && sel == 2'h1;
	endsequence

	sequence s_rd_halted;
		psel && penable && !pready && !pwrite && sel == 2'h2;
	endsequence

	a_reset_all_on: assert property (@(posedge mclk)
		!nrst |=> (st_r.grp_one == 8'hff && st_r.grp_two == 8'hff))
		else $error("clock-stop registers not all ones after reset");

	a_write_zero_stop: assert property (@(posedge mclk) disable iff (!nrst)
		(s_wr_grp_one and (pwdata[mcs_pkg::MCS_BIT_ADC] == 1'b0)) |=> !adc_clock_on)
		else $error("writing 0 did not stop the module clock");

	a_write_one_run: assert property (@(posedge mclk) disable iff (!nrst)
		(s_wr_grp_two and (pwdata[mcs_pkg::MCS_BIT_PWM_TWO] == 1'b1)) |=> pwm_two_clock_on)
		else $error("writing 1 did not restore the module clock");

	a_grp_one_map: assert property (@(posedge mclk) disable iff (!nrst)
		s_wr_grp_one |=> (timer_a_clock_on == $past(pwdata[0]) &&
			timer_f_clock_on == $past(pwdata[1]) && serial_if_clock_on == $past(pwdata[3])))
		else $error("group one bits drive wrong modules");

	a_grp_two_map: assert property (@(posedge mclk) disable iff (!nrst)
		s_wr_grp_two |=> (lcd_clock_on == $past(pwdata[0]) &&
			pwm_one_clock_on == $past(pwdata[1]) && event_counter_clock_on == $past(pwdata[2])))
		else $error("group two bits drive wrong modules");

	a_other_untouched: assert property (@(posedge mclk) disable iff (!nrst)
		s_wr_grp_one |=> $stable(st_r.grp_two))
		else $error("group one write disturbed group two");

	a_stopped_clk_low: assert property (@(posedge mclk) disable iff (!nrst)
		(!timer_a_clock_on ##1 !timer_a_clock_on) |-> !gate_en_q[mcs_pkg::MCS_MOD_TIMER_A])
		else $error("stopped module still has its clock");

	a_gate_latency: assert property (@(posedge mclk) disable iff (!nrst)
		gate_en_q == mod_en)
		else $error("gate enable not taken on the half cycle");

	a_apb_answer: assert property (@(posedge mclk) disable iff (!nrst)
		(psel && penable && !pready) |=> (pready ##1 !pready))
		else $error("pready not a single cycle after one wait");

	a_unmapped_err: assert property (@(posedge mclk) disable iff (!nrst)
		(psel && penable && !pready && sel == 2'h3) |=> (pslverr && prdata == 32'h0))
		else $error("unmapped address not refused");

	a_timer_f_stop: assert property (@(posedge mclk) disable iff (!nrst)
		(s_wr_grp_one and (pwdata[mcs_pkg::MCS_BIT_TIMER_F] == 1'b0)) |=> !timer_f_clock_on)
		else $error("writing 0 did not stop timer F");

	a_adc_run: assert property (@(posedge mclk) disable iff (!nrst)
		(s_wr_grp_one and (pwdata[mcs_pkg::MCS_BIT_ADC] == 1'b1)) |=> adc_clock_on)
		else $error("writing 1 did not restore the converter clock");

	a_serial_run: assert property (@(posedge mclk) disable iff (!nrst)
		(s_wr_grp_one and (pwdata[mcs_pkg::MCS_BIT_SERIAL] == 1'b1)) |=> serial_if_clock_on)
		else $error("writing 1 did not restore the serial clock");

	a_lcd_stop: assert property (@(posedge mclk) disable iff (!nrst)
		(s_wr_grp_two and (pwdata[mcs_pkg::MCS_BIT_LCD] == 1'b0)) |=> !lcd_clock_on)
		else $error("writing 0 did not stop the display clock");

	a_event_run: assert property (@(posedge mclk) disable iff (!nrst)
		(s_wr_grp_two and (pwdata[mcs_pkg::MCS_BIT_EVENT_CNT] == 1'b1)) |=> event_counter_clock_on)
		else $error("writing 1 did not restore the event counter clock");

	a_grp_two_isolated: assert property (@(posedge mclk) disable iff (!nrst)
		s_wr_grp_two |=> $stable(st_r.grp_one))
		else $error("group two write disturbed group one");

	a_reset_clocks_on: assert property (@(posedge mclk)
		!nrst |=> mod_en == 8'hff)
		else $error("module clocks not all running after reset");

	a_halted_view: assert property (@(posedge mclk) disable iff (!nrst)
		s_rd_halted |=> prdata == {24'h00_0000, ~$past(mod_en)})
		else $error("halted status does not match stopped clocks");

	a_strobe_off_ignored: assert property (@(posedge mclk) disable iff (!nrst)
		(psel && penable && !pready && pwrite && !pstrb[0]) |=>
			($stable(st_r.grp_one) && $stable(st_r.grp_two)))
		else $error("write without low byte strobe changed a register");

	a_unmapped_no_write: assert property (@(posedge mclk) disable iff (!nrst)
		(psel && penable && !pready && pwrite && sel == 2'h3) |=>
			($stable(st_r.grp_one) && $stable(st_r.grp_two)))
		else $error("unmapped write changed a register");

endmodule
`default_nettype wire

// ### shared/mcs_pkg.sv
// Operation
// - Each peripheral module has its own independent clock-stop control bit.
// - A module in standby gets no system clock and halts in place.
// - Writing 0 to a module's bit puts that module into standby.
// - Writing 1 to a module's bit ends standby and restores its clock.
// - Reset sets both clock-stop registers to all ones.
// - Group one holds timer A, timer F, A/D and serial interface bits.
// - Group two holds LCD, PWM one, event counter and PWM two bits.
package mcs_pkg;

	localparam int unsigned MCS_DATA_W = 32;
	localparam int unsigned MCS_REG_W = 8;
	localparam int unsigned MCS_MOD_N = 8;

	// Byte addresses on the APB
	localparam logic [7:0] MCS_OFS_GRP_ONE = 8'h00;
	localparam logic [7:0] MCS_OFS_GRP_TWO = 8'h04;
	localparam logic [7:0] MCS_OFS_HALTED = 8'h08;

	localparam logic [7:0] MCS_GRP_RESET = 8'hff;

	// Bit positions, group one
	localparam int unsigned MCS_BIT_TIMER_A = 0;
	localparam int unsigned MCS_BIT_TIMER_F = 1;
	localparam int unsigned MCS_BIT_ADC = 2;
	localparam int unsigned MCS_BIT_SERIAL = 3;
	// Bit positions, group two
	localparam int unsigned MCS_BIT_LCD = 0;
	localparam int unsigned MCS_BIT_PWM_ONE = 1;
	localparam int unsigned MCS_BIT_EVENT_CNT = 2;
	localparam int unsigned MCS_BIT_PWM_TWO = 3;

	// Index into the module clock vector
	localparam int unsigned MCS_MOD_TIMER_A = 0;
	localparam int unsigned MCS_MOD_TIMER_F = 1;
	localparam int unsigned MCS_MOD_ADC = 2;
	localparam int unsigned MCS_MOD_SERIAL = 3;
	localparam int unsigned MCS_MOD_LCD = 4;
	localparam int unsigned MCS_MOD_PWM_ONE = 5;
	localparam int unsigned MCS_MOD_EVENT_CNT = 6;
	localparam int unsigned MCS_MOD_PWM_TWO = 7;

	typedef struct packed {
		logic [7:0] grp_one;
		logic [7:0] grp_two;
		logic [31:0] prdata;
		logic pready;
		logic pslverr;
	} mcs_state_t;

	localparam mcs_state_t MCS_STATE_RESET = '{
		grp_one: MCS_GRP_RESET,
		grp_two: MCS_GRP_RESET,
		prdata: 32'h0000_0000,
		pready: 1'b0,
		pslverr: 1'b0
	};

endpackage

// ### rtl/mcs_clock_gate.sv
`timescale 1ns/1ps
`default_nettype none
module mcs_clock_gate (
	input wire logic mclk,
	input wire logic nrst,
	input wire logic en,
	output logic en_q,
	output logic gclk
);
	logic en_q_r;

	// Enable changes only while mclk is low, so no high phase is cut short
	always_ff @(negedge mclk) begin
		if (!nrst) begin
			en_q_r <= 1'b1;
		end else begin
			en_q_r <= en;
		end
	end

	assign en_q = en_q_r;
	assign gclk = mclk & en_q_r;

	a_gate_follow_en: assert property (@(negedge mclk) disable iff (!nrst)
		##1 en_q_r == $past(en))
		else $error("gate enable did not follow request");

endmodule
`default_nettype wire

// ### verif/mcs_periph_model.sv
`timescale 1ns/1ps
`default_nettype none
module mcs_periph_model (
	input wire logic [7:0] module_clk,
	output logic [7:0][15:0] edges,
	output logic [7:0] glitch
);
	realtime rise_t [8];
	initial begin
		edges = '0;
		glitch = '0;
	end
	for (genvar i = 0; i < 8; i++) begin : g_mod
		// Each peripheral advances only on its own clock
		always @(posedge module_clk[i]) begin
			edges[i] <= edges[i] + 16'h0001;
			rise_t[i] = $realtime;
		end
		// A high phase under 9 ns (a full mclk high phase is 10 ns) is a clipped pulse
		always @(negedge module_clk[i])
			if (rise_t[i] > 0.0 && $realtime - rise_t[i] < 9.0) glitch[i] <= 1'b1;
	end
endmodule
`default_nettype wire

// ### verif/module_clock_stop_control_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module module_clock_stop_control_tb_top;
	logic mclk = 1'b0, nrst = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [7:0] paddr = 8'h00, mclk_g, glitch, a, g1 = 8'hff, g2 = 8'hff;
	wire [7:0] on;
	logic [31:0] pwdata = 32'h0, prdata, rd, v;
	logic [3:0] pstrb = 4'h0;
	logic pready, pslverr, err;
	logic [7:0][15:0] edges, e0;
	int failures = 0, tests_run = 0, cycles = 0;
	always #10 mclk = ~mclk;
	mcs_top dut (.mclk(mclk), .nrst(nrst), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .timer_a_clock_on(on[0]), .timer_f_clock_on(on[1]),
		.adc_clock_on(on[2]), .serial_if_clock_on(on[3]), .lcd_clock_on(on[4]),
		.pwm_one_clock_on(on[5]), .event_counter_clock_on(on[6]), .pwm_two_clock_on(on[7]),
		.module_clk(mclk_g));
	mcs_periph_model periph (.module_clk(mclk_g), .edges(edges), .glitch(glitch));
	function automatic logic [7:0] exp_on(input logic [7:0] x, y);
		return {y[3:0], x[3:0]};
	endfunction
	task automatic chk(input string name, input logic [31:0] got, exp);
		tests_run++;
		if (got !== exp) begin
			failures++;
			$display("mismatch %s expected %h seen %h", name, exp, got);
		end
	endtask
	task automatic apb(input logic wr, input logic [7:0] ad, input logic [31:0] d,
		input logic [3:0] s);
		int n;
		@(posedge mclk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= ad;
		pwdata <= d;
		pstrb <= s;
		@(posedge mclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge mclk);
			n++;
		end while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		// One wait state: answer on the second access edge
		chk("wait_states", n, 32'h2);
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	// Count gated edges between falling edges, clear of the launch edge
	task automatic clk_check();
		logic [7:0] x;
		x = exp_on(g1, g2);
		@(negedge mclk);
		e0 = edges;
		repeat (6) @(negedge mclk);
		for (int i = 0; i < 8; i++)
			chk("module_clk", edges[i] - e0[i], x[i] ? 32'h6 : 32'h0);
		chk("clock_on", on, x);
		apb(1'b0, mcs_pkg::MCS_OFS_HALTED, 32'h0, 4'h0);
		chk("halted", rd, {24'h0, ~x});
	endtask
	task automatic final_report();
		$display("checks %0d failures %0d", tests_run, failures);
		if (failures == 0 && tests_run > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	always @(posedge mclk) begin
		cycles++;
		if (cycles == 20000) begin
			failures++;
			final_report();
		end
	end
	task automatic rd_both();
		apb(1'b0, mcs_pkg::MCS_OFS_GRP_ONE, 32'h0, 4'h0);
		chk("grp_one", rd, {24'h0, g1});
		apb(1'b0, mcs_pkg::MCS_OFS_GRP_TWO, 32'h0, 4'h0);
		chk("grp_two", rd, {24'h0, g2});
		clk_check();
	endtask
	initial begin
		void'($urandom(45120));
		repeat (10) @(posedge mclk);
		nrst <= 1'b1;
		rd_both();
		// First eight clear one bit each, then random patterns
		for (int i = 0; i < 24; i++) begin
			v = i < 8 ? ~(32'h1 << (i % 4)) : $urandom;
			a = i[2] ? mcs_pkg::MCS_OFS_GRP_TWO : mcs_pkg::MCS_OFS_GRP_ONE;
			apb(1'b1, a, v, 4'h1 | 4'($urandom));
			if (i[2]) g2 = v[7:0];
			else g1 = v[7:0];
			rd_both();
		end
		apb(1'b1, mcs_pkg::MCS_OFS_GRP_ONE, 32'h0, 4'he);
		// Status word is read only; a write must leave both groups alone
		apb(1'b1, mcs_pkg::MCS_OFS_HALTED, 32'h0, 4'hf);
		chk("halted_wr_err", err, 1'b0);
		apb(1'b1, 8'h0c, 32'h0, 4'hf);
		chk("pslverr", err, 1'b1);
		rd_both();
		nrst <= 1'b0;
		repeat (3) @(posedge mclk);
		nrst <= 1'b1;
		g1 = 8'hff;
		g2 = 8'hff;
		rd_both();
		chk("glitch", glitch, 8'h00);
		final_report();
	end
endmodule
`default_nettype wire
